// ==== pkg/ldc_pkg.sv ====
// Package with register map, field positions and timing constants of the LED config registers.
package ldc_pkg;
  // Register offsets.
  localparam logic [7:0] LDC_ADDR_CFG_ONE = 8'h00;
  localparam logic [7:0] LDC_ADDR_CFG_TWO = 8'h01;
  localparam logic [7:0] LDC_ADDR_WD_TAP = 8'h02;
  // Reset values.
  localparam logic [7:0] LDC_RST_CFG_ONE = 8'h10;
  localparam logic [7:0] LDC_RST_CFG_TWO = 8'h00;
  localparam logic [3:0] LDC_RST_WD_TAP = 4'h8;
  // Field positions of system_config_one.
  localparam int LDC_B_RELEASE = 7;
  localparam int LDC_B_PHASE = 6;
  localparam int LDC_B_LIMP = 5;
  localparam int LDC_B_WDEN = 4;
  localparam int LDC_B_CH2_INT = 3;
  localparam int LDC_B_CH2_EN = 2;
  localparam int LDC_B_CH1_INT = 1;
  localparam int LDC_B_CH1_EN = 0;
  // Field positions of system_config_two.
  localparam int LDC_B_TIMER_HI = 7;
  localparam int LDC_B_TIMER_LO = 6;
  localparam int LDC_B_CH2_LATCH_HI = 5;
  localparam int LDC_B_CH1_LATCH_HI = 2;
  localparam int LDC_LATCH_W = 3;
  // Fault latch bit order inside one channel group: thermal, high side, low side.
  localparam int LDC_F_THERMAL = 2;
  localparam int LDC_F_HIGHSIDE = 1;
  localparam int LDC_F_LOWSIDE = 0;
  // Watchdog counter and tap range.
  localparam int LDC_WD_W = 25;
  localparam int LDC_WD_TAP_BASE = 16;
  localparam logic [3:0] LDC_WD_TAP_MAX = 4'h8;
  localparam logic [3:0] LDC_WD_TAP_MASK = 4'hf;
  // Fault timer limits in microseconds and as clock counts.
  localparam int LDC_CLK_MHZ = 50;
  localparam int LDC_FT0_US = 3600;
  localparam int LDC_FT1_US = 7200;
  localparam int LDC_FT2_US = 14400;
  localparam int LDC_FT3_US = 28800;
  localparam int LDC_FT0_CYC = LDC_FT0_US * LDC_CLK_MHZ;
  localparam int LDC_FT1_CYC = LDC_FT1_US * LDC_CLK_MHZ;
  localparam int LDC_FT2_CYC = LDC_FT2_US * LDC_CLK_MHZ;
  localparam int LDC_FT3_CYC = LDC_FT3_US * LDC_CLK_MHZ;
  localparam int LDC_FT_W = 21;
  // Fault timer code values.
  localparam logic [1:0] LDC_FT_CODE0 = 2'h0;
  localparam logic [1:0] LDC_FT_CODE1 = 2'h1;
  localparam logic [1:0] LDC_FT_CODE2 = 2'h2;
endpackage : ldc_pkg

// ==== hdl/ldc_fault_chan.sv ====
// One LED channel's fault response: latch-off enable clear or auto-restart hold-off.
`timescale 1ns/1ps
`default_nettype none
module ldc_fault_chan (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Fault event pulses: thermal, high side, low side.
  input wire logic [2:0] fault_evt,
  // Latch-off selections in the same order.
  input wire logic [2:0] latch_sel,
  // Selected fault timer limit in clock cycles.
  input wire logic [20:0] limit_cyc,
  // Thermal fault still present (restart follows its hysteresis).
  input wire logic thermal_active,
  // Results.
  output logic latch_off,
  output logic restart_hold
);
  import ldc_pkg::*;

  typedef struct packed {
    logic [20:0] cnt;
    logic hold;
  } ldc_fc_state_t;

  ldc_fc_state_t s_q;
  ldc_fc_state_t s_d;
  logic [2:0] auto_evt;

  // An event with its latch bit set clears the enable; unlatched high or low side events start the hold-off.
  assign latch_off = |(fault_evt & latch_sel);
  assign auto_evt = fault_evt & ~latch_sel;
  assign restart_hold = s_q.hold | thermal_active;

  // Current-limit faults wait out the fault timer before the channel restarts.
  always_comb begin
    s_d = s_q;
    if (auto_evt[LDC_F_HIGHSIDE] | auto_evt[LDC_F_LOWSIDE]) begin
      s_d.hold = 1'b1;
      s_d.cnt = limit_cyc;
    end else if (s_q.hold) begin
      if (s_q.cnt <= 21'h000001) begin
        s_d.hold = 1'b0;
        s_d.cnt = '0;
      end else begin
        s_d.cnt = s_q.cnt - 21'h000001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : ldc_fault_chan
`default_nettype wire

// ==== hdl/ldc_config_regs.sv ====
// System configuration registers of a dual-channel LED driver with fault and watchdog hooks.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Host reads and writes every configuration register.
// - Config one at offset 0x00, resets to 0x10.
// - Writing 1 to bit 7 releases the fault output when no fault is active.
// - Bit 7 is write-only and always reads 0.
// - Bit 6 selects 180 or 0 degree phase between internal dimming signals.
// - Writing 1 to bit 5 enters limp-home.
// - Communication failure sets the limp-home bit.
// - Bit 4 enables the communication watchdog, reset value 1.
// - Bit 3 picks channel two duty source: pin or internal generator.
// - Bit 2 enables channel two, reset 0.
// - Bit 1 picks channel one duty source: pin or internal generator.
// - Bit 0 enables channel one, reset 0.
// - Config two at offset 0x01, resets to 0x00.
// - Config two: timer field bits 7:6, six per-fault latch selections below.
// - Timer codes select 3.6, 7.2, 14.4 or 28.8 ms.
// - Latch bit 1 clears channel enable; 0 auto-restarts.
// - Watchdog timeout taps bit 16 to 24 of a 25-bit counter, default 24.
module ldc_config_regs (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register access from the serial interface.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // A valid serial frame arrived; restarts the watchdog.
  input wire logic comm_kick,
  // Fault events per channel: thermal, high side, low side.
  input wire logic [2:0] ch1_fault_evt,
  input wire logic [2:0] ch2_fault_evt,
  input wire logic ch1_thermal_active,
  input wire logic ch2_thermal_active,
  // Any fault present in the system.
  input wire logic fault_active,
  // External dimming inputs and internal generator outputs.
  input wire logic channel_one_dim_input,
  input wire logic channel_two_dim_input,
  input wire logic ch1_int_dim,
  input wire logic ch2_int_dim,
  // Fault pin: open drain, asserted by any fault event.
  output logic fault_pin_o,
  output logic fault_pin_oe,
  // Controls to the rest of the device.
  output logic ch1_run,
  output logic ch2_run,
  output logic ch1_dim,
  output logic ch2_dim,
  output logic dimming_phase_select,
  output logic limp_home,
  output logic comm_watchdog_timeout,
  output logic [1:0] fault_timer_limit
);
  import ldc_pkg::*;

  typedef struct packed {
    logic [7:0] cfg_one;
    logic [7:0] cfg_two;
    logic [3:0] tap;
    logic [LDC_WD_W-1:0] wd_cnt;
    logic fault_pin;
  } ldc_state_t;

  ldc_state_t s_q;
  ldc_state_t s_d;
  logic [20:0] limit_cyc;
  logic ch1_latch;
  logic ch2_latch;
  logic ch1_hold;
  logic ch2_hold;
  logic wd_tap_hit;
  logic wr_one;

  // Map a tap register value to a counter bit index; codes above 8 clamp to bit 24.
  function automatic logic [4:0] ldc_tap_bit(input logic [3:0] code);
    logic [3:0] c;
    c = (code > LDC_WD_TAP_MAX) ? LDC_WD_TAP_MAX : code;
    ldc_tap_bit = 5'(LDC_WD_TAP_BASE) + {1'b0, c};
  endfunction : ldc_tap_bit

  // Select the fault timer length from the two-bit code.
  always_comb begin
    case (s_q.cfg_two[LDC_B_TIMER_HI:LDC_B_TIMER_LO])
      LDC_FT_CODE0: limit_cyc = 21'(LDC_FT0_CYC);
      LDC_FT_CODE1: limit_cyc = 21'(LDC_FT1_CYC);
      LDC_FT_CODE2: limit_cyc = 21'(LDC_FT2_CYC);
      default: limit_cyc = 21'(LDC_FT3_CYC);
    endcase
  end

  // Channel one fault response.
  ldc_fault_chan u_ch1 (
    .clk(clk),
    .reset(reset),
    .fault_evt(ch1_fault_evt),
    .latch_sel(s_q.cfg_two[LDC_B_CH1_LATCH_HI -: LDC_LATCH_W]),
    .limit_cyc(limit_cyc),
    .thermal_active(ch1_thermal_active),
    .latch_off(ch1_latch),
    .restart_hold(ch1_hold)
  );

  // Channel two fault response.
  ldc_fault_chan u_ch2 (
    .clk(clk),
    .reset(reset),
    .fault_evt(ch2_fault_evt),
    .latch_sel(s_q.cfg_two[LDC_B_CH2_LATCH_HI -: LDC_LATCH_W]),
    .limit_cyc(limit_cyc),
    .thermal_active(ch2_thermal_active),
    .latch_off(ch2_latch),
    .restart_hold(ch2_hold)
  );

  assign wr_one = reg_wr && (reg_addr == LDC_ADDR_CFG_ONE);
  assign wd_tap_hit = s_q.wd_cnt[ldc_tap_bit(s_q.tap)];

  // Next-state logic: host writes, then hardware events that must win over them.
  always_comb begin
    s_d = s_q;
    // Watchdog counts only while enabled and restarts on every frame.
    if (!s_q.cfg_one[LDC_B_WDEN] || comm_kick) begin
      s_d.wd_cnt = '0;
    end else if (!wd_tap_hit) begin
      s_d.wd_cnt = s_q.wd_cnt + 25'h0000001;
    end
    if (reg_wr) begin
      case (reg_addr)
        LDC_ADDR_CFG_ONE: begin
          s_d.cfg_one = reg_wdata;
          s_d.cfg_one[LDC_B_RELEASE] = 1'b0;
        end
        LDC_ADDR_CFG_TWO: begin
          s_d.cfg_two = reg_wdata;
        end
        LDC_ADDR_WD_TAP: begin
          s_d.tap = reg_wdata[3:0] & LDC_WD_TAP_MASK;
        end
        default: begin
          s_d.cfg_two = s_q.cfg_two;
        end
      endcase
    end
    // Release the fault pin on request only if nothing is faulted.
    if (wr_one && reg_wdata[LDC_B_RELEASE] && !fault_active) begin
      s_d.fault_pin = 1'b0;
    end
    // A new fault event sets the pin and beats a same-cycle release.
    if (|{ch1_fault_evt, ch2_fault_evt}) begin
      s_d.fault_pin = 1'b1;
    end
    // Communication failure forces limp-home; the set wins over a host clear.
    if (s_q.cfg_one[LDC_B_WDEN] && wd_tap_hit) begin
      s_d.cfg_one[LDC_B_LIMP] = 1'b1;
    end
    // Latch-off faults clear the enable, beating a same-cycle host write.
    if (ch1_latch) begin
      s_d.cfg_one[LDC_B_CH1_EN] = 1'b0;
    end
    if (ch2_latch) begin
      s_d.cfg_one[LDC_B_CH2_EN] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q.cfg_one <= LDC_RST_CFG_ONE;
      s_q.cfg_two <= LDC_RST_CFG_TWO;
      s_q.tap <= LDC_RST_WD_TAP;
      s_q.wd_cnt <= '0;
      s_q.fault_pin <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Read data is registered-state only; bit 7 of config one is never stored.
  always_comb begin
    case (reg_addr)
      LDC_ADDR_CFG_ONE: reg_rdata = s_q.cfg_one;
      LDC_ADDR_CFG_TWO: reg_rdata = s_q.cfg_two;
      LDC_ADDR_WD_TAP: reg_rdata = {4'h0, s_q.tap};
      default: reg_rdata = 8'h00;
    endcase
  end

  // Channel controls; restart hold-off keeps an auto-restart channel dark.
  assign ch1_run = s_q.cfg_one[LDC_B_CH1_EN] & ~ch1_hold;
  assign ch2_run = s_q.cfg_one[LDC_B_CH2_EN] & ~ch2_hold;
  assign ch1_dim = s_q.cfg_one[LDC_B_CH1_INT] ? ch1_int_dim : channel_one_dim_input;
  assign ch2_dim = s_q.cfg_one[LDC_B_CH2_INT] ? ch2_int_dim : channel_two_dim_input;
  assign dimming_phase_select = s_q.cfg_one[LDC_B_PHASE];
  assign limp_home = s_q.cfg_one[LDC_B_LIMP];
  assign comm_watchdog_timeout = s_q.cfg_one[LDC_B_WDEN] & wd_tap_hit;
  assign fault_timer_limit = s_q.cfg_two[LDC_B_TIMER_HI:LDC_B_TIMER_LO];
  // Open drain: only ever drives low, while the pin is asserted.
  assign fault_pin_o = 1'b0;
  assign fault_pin_oe = s_q.fault_pin;
endmodule : ldc_config_regs
`default_nettype wire

// ==== bench/ldc_props.sv ====
// Assertion checker for the LED configuration register block.
`timescale 1ns/1ps
`default_nettype none
module ldc_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register access.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Fault inputs.
  input wire logic [2:0] ch1_fault_evt,
  input wire logic [2:0] ch2_fault_evt,
  input wire logic fault_active,
  // Watched outputs.
  input wire logic fault_pin_oe,
  input wire logic ch1_run,
  input wire logic ch2_run,
  input wire logic dimming_phase_select,
  input wire logic limp_home,
  input wire logic comm_watchdog_timeout,
  input wire logic [1:0] fault_timer_limit
);
  // One clock domain, so clocking and reset are stated once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Mirror of the channel-one thermal latch selection, taken from host writes.
  logic ch1_th_latch_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      ch1_th_latch_q <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h01) begin
      ch1_th_latch_q <= reg_wdata[2];
    end
  end
  // A host write to the first register.
  sequence s_wr_one;
    reg_wr && reg_addr == 8'h00;
  endsequence
  // A release write with no fault present or arriving in that cycle.
  sequence s_release;
    s_wr_one ##0 (reg_wdata[7] && !fault_active && (ch1_fault_evt | ch2_fault_evt) == 3'h0);
  endsequence
  a_release_reads_zero: assert property (
    reg_addr == 8'h00 |-> !reg_rdata[7]) else $error("Release bit reads one.");
  a_release_frees_pin: assert property (
    s_release |=> !fault_pin_oe) else $error("Fault pin not released.");
  a_phase_follows: assert property (
    s_wr_one |=> dimming_phase_select == $past(reg_wdata[6])) else $error("Phase not stored.");
  a_timer_follows: assert property (
    reg_wr && reg_addr == 8'h01 |=> fault_timer_limit == $past(reg_wdata[7:6]))
    else $error("Timer field not stored.");
  a_timeout_sets_limp: assert property (
    comm_watchdog_timeout |=> limp_home) else $error("Timeout did not set limp-home.");
  a_limp_held: assert property (
    limp_home && !(reg_wr && reg_addr == 8'h00) |=> limp_home) else $error("Limp-home dropped.");
  a_off_no_timeout: assert property (
    reg_addr == 8'h00 && !reg_rdata[4] |-> !comm_watchdog_timeout)
    else $error("Timeout while watchdog off.");
  a_off_no_run: assert property (
    reg_addr == 8'h00 |-> (reg_rdata[0] || !ch1_run) && (reg_rdata[2] || !ch2_run))
    else $error("Channel runs while disabled.");
  a_latch_stops_run: assert property (
    ch1_th_latch_q && ch1_fault_evt[2] |=> !ch1_run)
    else $error("Latch-off left channel running.");
endmodule : ldc_props
bind ldc_config_regs ldc_props u_props (.clk, .reset, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rdata, .ch1_fault_evt, .ch2_fault_evt, .fault_active, .fault_pin_oe, .ch1_run,
  .ch2_run, .dimming_phase_select, .limp_home, .comm_watchdog_timeout, .fault_timer_limit);
`default_nettype wire

// ==== bench/ldc_host.sv ====
// Host model that reads and writes the configuration registers.
`timescale 1ns/1ps
`default_nettype none
module ldc_host (
  // Clock.
  input wire logic clk,
  // Register access toward the device.
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // Idle bus with no strobe.
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // Strobe for one rising edge; data is then inverted so stale data is never reused.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  // The answer is combinational; sampling well before the next edge avoids a race.
  // The task ends on a falling edge, so whatever the caller drives next lands there.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    #5;
    d = reg_rdata;
    @(negedge clk);
  endtask : rd
endmodule : ldc_host
`default_nettype wire

// ==== bench/tb_ldc_config_regs.sv ====
// Testbench for the LED configuration register block.
`timescale 1ns/1ps
`default_nettype none
module tb_ldc_config_regs;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_wr, fault_pin_o, fault_pin_oe, ch1_run, ch2_run, ch1_dim, ch2_dim;
  logic comm_kick = 1'b0;
  logic fault_active = 1'b0;
  logic [2:0] ch1_fault_evt = 3'h0;
  logic [2:0] ch2_fault_evt = 3'h0;
  logic ch1_thermal_active = 1'b0;
  logic ch2_thermal_active = 1'b0;
  logic dimming_phase_select, limp_home, comm_watchdog_timeout;
  logic [1:0] fault_timer_limit;
  logic [3:0] dim_cnt = 4'h0;
  int failures = 0;
  int n_tests = 0;
  wire channel_one_dim_input = dim_cnt[0];
  wire channel_two_dim_input = dim_cnt[1];
  wire ch1_int_dim = dim_cnt[2];
  wire ch2_int_dim = dim_cnt[3];
  ldc_config_regs uut (.clk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .comm_kick,
    .ch1_fault_evt, .ch2_fault_evt, .ch1_thermal_active, .ch2_thermal_active, .fault_active,
    .channel_one_dim_input, .channel_two_dim_input, .ch1_int_dim, .ch2_int_dim, .fault_pin_o,
    .fault_pin_oe, .ch1_run, .ch2_run, .ch1_dim, .ch2_dim, .dimming_phase_select, .limp_home,
    .comm_watchdog_timeout, .fault_timer_limit);
  ldc_host host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata);
  // Clock and a moving pattern on every dimming source.
  always #10 clk = ~clk;
  always @(negedge clk) dim_cnt <= dim_cnt + 4'h1;
  // Count each compare; report a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv);
    chk(rv, e);
  endtask : rc
  // Dim mux over four cycles, so pin and generator patterns differ at least once.
  task automatic chk_dim(input logic internal);
    repeat (4) begin
      @(negedge clk);
      if (internal) begin
        chk({6'h0, ch2_dim, ch1_dim}, {6'h0, ch2_int_dim, ch1_int_dim});
      end else begin
        chk({6'h0, ch2_dim, ch1_dim}, {6'h0, channel_two_dim_input, channel_one_dim_input});
      end
    end
  endtask : chk_dim
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  // Stop a hung run well past the expected length.
  initial begin
    #1700000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    rc(8'h00, 8'h10);
    rc(8'h01, 8'h00);
    rc(8'h02, 8'h08);
    rc(8'h05, 8'h00);
    $display("test reset_values done");
    host.wr(8'h00, 8'hef);
    rc(8'h00, 8'h6f);
    chk_dim(1'b1);
    chk({5'h0, dimming_phase_select, ch2_run, ch1_run}, 8'h07);
    host.wr(8'h00, 8'h05);
    rc(8'h00, 8'h05);
    chk_dim(1'b0);
    chk({7'h0, dimming_phase_select}, 8'h00);
    host.wr(8'h02, 8'hff);
    rc(8'h02, 8'h0f);
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h01, {i[1:0], 6'h2a});
      rc(8'h01, {i[1:0], 6'h2a});
      chk({6'h0, fault_timer_limit}, {6'h0, i[1:0]});
    end
    $display("test read_write done");
    // Latch-off on ch1 thermal and ch2 low side.
    host.wr(8'h01, 8'h0c);
    host.wr(8'h00, 8'h05);
    @(negedge clk);
    ch1_fault_evt = 3'h4;
    ch2_fault_evt = 3'h1;
    @(negedge clk);
    ch1_fault_evt = 3'h0;
    ch2_fault_evt = 3'h0;
    rc(8'h00, 8'h00);
    chk({4'h0, fault_pin_o, fault_pin_oe, ch2_run, ch1_run}, 8'h04);
    fault_active = 1'b1;
    host.wr(8'h00, 8'h80);
    chk({7'h0, fault_pin_oe}, 8'h01);
    fault_active = 1'b0;
    host.wr(8'h00, 8'h80);
    chk({7'h0, fault_pin_oe}, 8'h00);
    // Auto-restart: thermal follows its level, a current limit starts the hold-off.
    host.wr(8'h01, 8'h00);
    host.wr(8'h00, 8'h05);
    ch1_thermal_active = 1'b1;
    @(negedge clk);
    chk({6'h0, ch2_run, ch1_run}, 8'h02);
    ch1_thermal_active = 1'b0;
    ch2_fault_evt = 3'h2;
    @(negedge clk);
    ch2_fault_evt = 3'h0;
    chk({6'h0, ch2_run, ch1_run}, 8'h01);
    $display("test fault_handling done");
    host.wr(8'h00, 8'h20);
    chk({7'h0, limp_home}, 8'h01);
    host.wr(8'h00, 8'h00);
    chk({7'h0, limp_home}, 8'h00);
    // Tap at bit 16: a kick midway must restart the count.
    host.wr(8'h02, 8'h00);
    host.wr(8'h00, 8'h10);
    // Without the kick the count would pass bit 16 well before the first check.
    repeat (10000) @(negedge clk);
    comm_kick = 1'b1;
    @(negedge clk);
    comm_kick = 1'b0;
    repeat (60000) @(negedge clk);
    chk({7'h0, limp_home}, 8'h00);
    for (int i = 0; i < 20000 && limp_home !== 1'b1; i++) @(negedge clk);
    chk({6'h0, comm_watchdog_timeout, limp_home}, 8'h03);
    repeat (10) @(negedge clk);
    chk({7'h0, limp_home}, 8'h01);
    // A clear that meets a pending timeout loses; once the watchdog is off it takes.
    host.wr(8'h00, 8'h00);
    chk({7'h0, limp_home}, 8'h01);
    host.wr(8'h00, 8'h00);
    chk({6'h0, comm_watchdog_timeout, limp_home}, 8'h00);
    $display("test watchdog done");
    give_verdict();
  end
endmodule : tb_ldc_config_regs
`default_nettype wire
